/* File: rtl/sci_pkg.sv */
// constants shared by the smart card interrupt enable block
package sci_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources, shared by enable and status layouts
  localparam int NUM_SRC = 11;
  localparam int RSV_W = DATA_W - NUM_SRC;
  localparam int BIT_CONV_ERR = 10;
  localparam int BIT_RX_TIMEOUT = 9;
  localparam int BIT_SEQ_DONE = 8;
  localparam int BIT_CARD_DETECT = 7;
  localparam int BIT_BLOCK_GUARD = 6;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_TIMER1 = 4;
  localparam int BIT_TIMER0 = 3;
  localparam int BIT_TRANSFER_ERR = 2;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_RX_LEVEL = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and flag classes
  localparam logic [NUM_SRC-1:0] IRQ_ENABLE_RESET = 11'h000;
  localparam logic [NUM_SRC-1:0] IRQ_STATUS_RESET = 11'h002;
  // sticky flags are set by events and cleared by writing one
  localparam logic [NUM_SRC-1:0] STICKY_MASK = 11'h578;

  ////////////////////////////////////////////////////////////////////////////
  // initial character values that name a valid convention
  localparam logic [7:0] INIT_CHAR_DIRECT = 8'h3b;
  localparam logic [7:0] INIT_CHAR_INVERSE = 8'h3f;

endpackage

/* File: rtl/sci_flag_if.sv */
// carrier between the register logic and the status flag bank
`timescale 1ns/1ps
`default_nettype none
interface sci_flag_if import sci_pkg::*; ();
  logic [NUM_SRC-1:0] set;
  logic [NUM_SRC-1:0] level;
  logic [NUM_SRC-1:0] clear;
  logic [NUM_SRC-1:0] status;

  modport bank (input set, input level, input clear, output status);
  modport ctrl (output set, output level, output clear, input status);
endinterface
`default_nettype wire

/* File: rtl/sci_flag_bank.sv */
// interrupt status flags: sticky write-one-to-clear bits and level bits
`timescale 1ns/1ps
`default_nettype none
module sci_flag_bank import sci_pkg::*;
#(
  parameter logic [NUM_SRC-1:0] STICKY = STICKY_MASK,
  parameter logic [NUM_SRC-1:0] RESET_VAL = IRQ_STATUS_RESET
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // flag traffic
  sci_flag_if.bank fl
);

  logic [NUM_SRC-1:0] status;
  logic [NUM_SRC-1:0] next_status;

  ////////////////////////////////////////////////////////////////////////////
  // a set in the clear cycle wins so no event is lost
  always_comb
  begin
    next_status = ((status & ~fl.clear) | fl.set) & STICKY;
    next_status = next_status | (fl.level & ~STICKY);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      status <= RESET_VAL;
    else
      status <= next_status;
  end

  assign fl.status = status;

  ////////////////////////////////////////////////////////////////////////////
  a_set_wins_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fl.set & fl.clear & STICKY) != 11'h000
    |=> (status & $past(fl.set & fl.clear & STICKY))
        == $past(fl.set & fl.clear & STICKY))
    else $error("sticky flag lost to a same-cycle clear");

  a_sticky_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fl.clear == 11'h000) && (fl.set == 11'h000)
    |=> ((status & STICKY) == ($past(status) & STICKY)))
    else $error("sticky flag changed without set or clear");

endmodule
`default_nettype wire

/* File: rtl/sci_irq_ctrl.sv */
// smart card interrupt enable register, status flags and interrupt output
// What this block does
// - enable register at 0x18, read/write, resets to zero, bits 31:11 zero
// - bit 10 gates the convention error interrupt
// - bit 9 gates the receive buffer time-out interrupt
// - bit 8 gates the shared activation, deactivation, warm reset end
// - bit 7 gates card detect: card inserted or card removed flag set
// - bit 6 gates the block guard time interrupt
// - bits 5, 4, 3 gate timers 2, 1, 0 independently
// - bit 2 gates the combined transfer error interrupt of seven sources
// - bit 1 gates the transmit buffer empty interrupt
// - bit 0 gates receive fill reaching the programmed trigger level
// - convention error when the initial character is not 0x3b or 0x3f
// - status register at 0x1c, most flags cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module sci_irq_ctrl import sci_pkg::*;
#(
  parameter int FILL_W = 4
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // answer-to-reset initial character
  input wire logic init_char_valid,
  input wire logic [7:0] init_char,
  // sequence, guard time and timer events, one-cycle pulses
  input wire logic sequence_done,
  input wire logic block_guard_event,
  input wire logic [2:0] timer_event,
  // level conditions from the receiver, transmitter and pins
  input wire logic rx_timeout_state,
  input wire logic card_inserted_flag,
  input wire logic card_removed_flag,
  input wire logic rx_break_err,
  input wire logic rx_framing_err,
  input wire logic rx_parity_err,
  input wire logic rx_overflow_err,
  input wire logic tx_overflow_err,
  input wire logic rx_retry_limit_err,
  input wire logic tx_retry_limit_err,
  input wire logic tx_empty,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [FILL_W-1:0] rx_trigger_level,
  // interrupt request
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register access decode
  logic wr_enable;
  logic wr_status;
  logic rd_enable;
  logic rd_status;

  assign wr_enable = reg_wr && (reg_addr == OFS_IRQ_ENABLE);
  assign wr_status = reg_wr && (reg_addr == OFS_IRQ_STATUS);
  assign rd_enable = reg_rd && (reg_addr == OFS_IRQ_ENABLE);
  assign rd_status = reg_rd && (reg_addr == OFS_IRQ_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enable register
  logic [NUM_SRC-1:0] irq_enable_reg;
  logic [NUM_SRC-1:0] next_irq_enable_reg;

  always_comb
  begin
    next_irq_enable_reg = irq_enable_reg;
    if (wr_enable)
      next_irq_enable_reg = reg_wdata[NUM_SRC-1:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_enable_reg <= IRQ_ENABLE_RESET;
    else
      irq_enable_reg <= next_irq_enable_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event sources into the flag bank
  sci_flag_if flags ();

  logic convention_err;
  logic transfer_err;
  logic rx_level_hit;

  // both valid conventions are compared, anything else is an error
  assign convention_err = init_char_valid &&
                          (init_char != INIT_CHAR_DIRECT) &&
                          (init_char != INIT_CHAR_INVERSE);
  assign transfer_err = rx_break_err | rx_framing_err | rx_parity_err |
                        rx_overflow_err | tx_overflow_err |
                        rx_retry_limit_err | tx_retry_limit_err;
  assign rx_level_hit = (rx_fill >= rx_trigger_level);

  always_comb
  begin
    flags.set = '0;
    flags.level = '0;
    flags.set[BIT_CONV_ERR] = convention_err;
    flags.set[BIT_SEQ_DONE] = sequence_done;
    flags.set[BIT_BLOCK_GUARD] = block_guard_event;
    flags.set[BIT_TIMER2] = timer_event[2];
    flags.set[BIT_TIMER1] = timer_event[1];
    flags.set[BIT_TIMER0] = timer_event[0];
    // time-out follows the receiver state, a write cannot clear it
    flags.level[BIT_RX_TIMEOUT] = rx_timeout_state;
    flags.level[BIT_CARD_DETECT] = card_inserted_flag |
                                   card_removed_flag;
    flags.level[BIT_TRANSFER_ERR] = transfer_err;
    flags.level[BIT_TX_EMPTY] = tx_empty;
    flags.level[BIT_RX_LEVEL] = rx_level_hit;
  end

  // only sticky bits take a write-one clear
  assign flags.clear = wr_status ? (reg_wdata[NUM_SRC-1:0] & STICKY_MASK)
                                 : 11'h000;

  sci_flag_bank
  #(
    .STICKY(STICKY_MASK),
    .RESET_VAL(IRQ_STATUS_RESET)
  )
  u_flag_bank
  (
    .clock(clock),
    .rst_n(rst_n),
    .fl(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe
  logic [DATA_W-1:0] next_reg_rdata;

  always_comb
  begin
    next_reg_rdata = '0;
    if (rd_enable)
      next_reg_rdata = {{RSV_W{1'b0}}, irq_enable_reg};
    else if (rd_status)
      next_reg_rdata = {{RSV_W{1'b0}}, flags.status};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= next_reg_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output; combinational so a clear drops it at once
  assign irq = |(flags.status & irq_enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_enable_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_enable |=> irq_enable_reg == $past(reg_wdata[NUM_SRC-1:0]))
    else $error("enable register did not take the write");

  a_enable_readback: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd_enable && !wr_enable
    |=> reg_rdata == {{RSV_W{1'b0}}, $past(irq_enable_reg)})
    else $error("enable readback wrong or reserved bits set");

  a_conv_err_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    init_char_valid && (init_char != 8'h3b) && (init_char != 8'h3f)
    |=> flags.status[BIT_CONV_ERR])
    else $error("bad initial character did not flag an error");

  a_conv_ok_quiet: assert property (
    @(posedge clock) disable iff (!rst_n)
    !flags.status[BIT_CONV_ERR] &&
    (!init_char_valid || init_char == 8'h3b || init_char == 8'h3f)
    |=> !flags.status[BIT_CONV_ERR])
    else $error("convention error raised for a valid character");

  a_conv_err_irq: assert property (
    @(posedge clock) disable iff (!rst_n)
    convention_err && irq_enable_reg[BIT_CONV_ERR] && !wr_enable
    |=> irq)
    else $error("enabled convention error gave no interrupt");

  a_timeout_follow: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 flags.status[BIT_RX_TIMEOUT] == $past(rx_timeout_state))
    else $error("time-out flag does not follow the receiver");

  a_timeout_no_w1c: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_status && rx_timeout_state |=> flags.status[BIT_RX_TIMEOUT])
    else $error("write cleared the time-out flag");

  a_seq_done_irq: assert property (
    @(posedge clock) disable iff (!rst_n)
    sequence_done && irq_enable_reg[BIT_SEQ_DONE] && !wr_enable
    |=> irq ##0 flags.status[BIT_SEQ_DONE])
    else $error("sequence end gave no interrupt");

  a_card_detect: assert property (
    @(posedge clock) disable iff (!rst_n)
    (card_inserted_flag || card_removed_flag)
    |=> flags.status[BIT_CARD_DETECT])
    else $error("card detect flag not set");

  a_guard_irq: assert property (@(posedge clock) disable iff (!rst_n)
    block_guard_event && irq_enable_reg[BIT_BLOCK_GUARD] && !wr_enable
    |=> irq)
    else $error("block guard event gave no interrupt");

  a_timer_flags: assert property (
    @(posedge clock) disable iff (!rst_n)
    timer_event != 3'h0
    |=> (flags.status[BIT_TIMER2:BIT_TIMER0] & $past(timer_event))
        == $past(timer_event))
    else $error("timer event did not set its own flag");

  a_transfer_err: assert property (
    @(posedge clock) disable iff (!rst_n)
    ##1 flags.status[BIT_TRANSFER_ERR] ==
        $past(rx_break_err || rx_framing_err || rx_parity_err ||
              rx_overflow_err || tx_overflow_err ||
              rx_retry_limit_err || tx_retry_limit_err))
    else $error("transfer error flag does not match its sources");

  a_tx_empty: assert property (@(posedge clock) disable iff (!rst_n)
    tx_empty && irq_enable_reg[BIT_TX_EMPTY] && !wr_enable |=> irq)
    else $error("empty transmit buffer gave no interrupt");

  a_rx_level: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 flags.status[BIT_RX_LEVEL] ==
        $past(rx_fill >= rx_trigger_level))
    else $error("receive level flag wrong");

  a_w1c_clear: assert property (@(posedge clock) disable iff (!rst_n)
    wr_status && reg_wdata[BIT_TIMER0] && !timer_event[0]
    |=> !flags.status[BIT_TIMER0])
    else $error("write of one did not clear the timer flag");

  a_irq_masked: assert property (
    @(posedge clock) disable iff (!rst_n)
    irq_enable_reg == 11'h000 |-> !irq)
    else $error("interrupt raised with every source disabled");

  a_irq_drops: assert property (@(posedge clock) disable iff (!rst_n)
    irq && wr_enable && (reg_wdata[NUM_SRC-1:0] == 11'h000)
    |=> !irq)
    else $error("interrupt stayed after disabling all sources");

  // read data fall back to zero so a stale word is never taken for data
  a_rdata_idle: assert property (
    @(posedge clock) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");

  a_status_readback: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd_status |=> reg_rdata == {{RSV_W{1'b0}}, $past(flags.status)})
    else $error("status readback wrong or reserved bits set");

  a_enable_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !wr_enable |=> $stable(irq_enable_reg))
    else $error("enable register changed without a write");

  a_card_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    !card_inserted_flag && !card_removed_flag
    |=> !flags.status[BIT_CARD_DETECT])
    else $error("card detect flag stayed without a pin flag");

  a_level_no_w1c: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_status && transfer_err |=> flags.status[BIT_TRANSFER_ERR])
    else $error("write cleared the transfer error flag");

endmodule
`default_nettype wire

/* File: tb/sci_card_model.sv */
// far-side model: turns bench requests into card, timer and transfer events
`timescale 1ns/1ps
`default_nettype none
module sci_card_model import sci_pkg::*;
(
  // clock
  input wire logic clock,
  // bench requests, one per status bit
  input wire logic [NUM_SRC-1:0] req,
  input wire logic [2:0] err_sel,
  input wire logic [7:0] conv_char,
  // towards the block
  output logic init_char_valid,
  output logic [7:0] init_char,
  output logic sequence_done,
  output logic block_guard_event,
  output logic [2:0] timer_event,
  output logic rx_timeout_state,
  output logic card_inserted_flag,
  output logic card_removed_flag,
  output logic [6:0] err_vec,
  output logic tx_empty,
  output logic [3:0] rx_fill,
  output logic [3:0] rx_trigger_level
);
  logic [NUM_SRC-1:0] req_q;
  logic [NUM_SRC-1:0] pulse;

  always_ff @(posedge clock) req_q <= req;
  // events are one-cycle pulses, so a held request fires only once
  assign pulse = req & ~req_q;
  assign init_char_valid = pulse[BIT_CONV_ERR];
  // the character lines carry junk outside the strobe
  assign init_char = init_char_valid ? conv_char : ~conv_char;
  assign sequence_done = pulse[BIT_SEQ_DONE];
  assign block_guard_event = pulse[BIT_BLOCK_GUARD];
  assign timer_event = pulse[BIT_TIMER2:BIT_TIMER0];
  // held as long as the bench holds its request bit, status writes do not clear
  assign rx_timeout_state = req[BIT_RX_TIMEOUT];
  assign card_inserted_flag = req[BIT_CARD_DETECT] & ~err_sel[0];
  assign card_removed_flag = req[BIT_CARD_DETECT] & err_sel[0];
  assign err_vec = req[BIT_TRANSFER_ERR] ? 7'h01 << err_sel : 7'h00;
  assign tx_empty = req[BIT_TX_EMPTY];
  // fill sits one below the level unless asked to reach it
  assign rx_trigger_level = 4'h5;
  assign rx_fill = req[BIT_RX_LEVEL] ? 4'h5 : 4'h4;
endmodule
`default_nettype wire

/* File: tb/sci_irq_ctrl_tb.sv */
// self-checking bench for the smart card interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module sci_irq_ctrl_tb import sci_pkg::*;
;
  logic clock, nrst, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, conv_char, init_char;
  logic [31:0] reg_wdata, reg_rdata, rdat, bit_m;
  logic [NUM_SRC-1:0] req;
  logic [2:0] err_sel, timer_event;
  logic init_char_valid, sequence_done, block_guard_event, rx_timeout_state;
  logic card_inserted_flag, card_removed_flag, tx_empty;
  logic [6:0] err_vec;
  logic [3:0] rx_fill, rx_trigger_level;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  sci_irq_ctrl #(.FILL_W(4)) i_dut (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .init_char_valid(init_char_valid), .init_char(init_char),
    .sequence_done(sequence_done), .block_guard_event(block_guard_event),
    .timer_event(timer_event), .rx_timeout_state(rx_timeout_state),
    .card_inserted_flag(card_inserted_flag),
    .card_removed_flag(card_removed_flag),
    .rx_break_err(err_vec[0]), .rx_framing_err(err_vec[1]),
    .rx_parity_err(err_vec[2]), .rx_overflow_err(err_vec[3]),
    .tx_overflow_err(err_vec[4]), .rx_retry_limit_err(err_vec[5]),
    .tx_retry_limit_err(err_vec[6]), .tx_empty(tx_empty),
    .rx_fill(rx_fill), .rx_trigger_level(rx_trigger_level), .irq(irq));

  sci_card_model i_card (.clock(clock), .req(req), .err_sel(err_sel),
    .conv_char(conv_char), .init_char_valid(init_char_valid),
    .init_char(init_char), .sequence_done(sequence_done),
    .block_guard_event(block_guard_event), .timer_event(timer_event),
    .rx_timeout_state(rx_timeout_state),
    .card_inserted_flag(card_inserted_flag),
    .card_removed_flag(card_removed_flag), .err_vec(err_vec),
    .tx_empty(tx_empty), .rx_fill(rx_fill),
    .rx_trigger_level(rx_trigger_level));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // one edge to take the event, one for the status to show
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic drive(input logic [NUM_SRC-1:0] r);
    @(posedge clock);
    req <= r;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req = '0;
    err_sel = 3'h0;
    conv_char = 8'h55;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFS_IRQ_ENABLE, rdat);
    chk("enable reset", rdat, 32'h0);
    rd(OFS_IRQ_STATUS, rdat);
    chk("status reset", rdat, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'hffff_ffff);
    rd(OFS_IRQ_ENABLE, rdat);
    chk("enable reserved", rdat, 32'h0000_07ff);
    wr(8'h20, 32'h0);
    rd(8'h20, rdat);
    chk("unmapped read", rdat, 32'h0);
    rd(OFS_IRQ_ENABLE, rdat);
    chk("enable kept", rdat, 32'h0000_07ff);
    chk("irq idle", {31'h0, irq}, 32'h0);
    for (int i = 0; i < NUM_SRC; i++)
    begin
      bit_m = 32'h1 << i;
      wr(OFS_IRQ_ENABLE, ~bit_m);
      drive(bit_m[NUM_SRC-1:0]);
      settle();
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(OFS_IRQ_ENABLE, bit_m);
      settle();
      chk("irq raised", {31'h0, irq}, 32'h1);
      wr(OFS_IRQ_STATUS, bit_m);
      rd(OFS_IRQ_STATUS, rdat);
      chk("status clear", rdat, bit_m & ~32'(STICKY_MASK));
      drive('0);
      settle();
      chk("irq dropped", {31'h0, irq}, 32'h0);
      rd(OFS_IRQ_STATUS, rdat);
      chk("status idle", rdat, 32'h0);
    end
    for (int s = 0; s < 7; s++)
    begin
      @(posedge clock);
      err_sel <= 3'(s);
      drive(11'h084);
      settle();
      rd(OFS_IRQ_STATUS, rdat);
      chk("error source", rdat, 32'h0000_0084);
      drive('0);
      settle();
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      conv_char <= (k == 0) ? INIT_CHAR_DIRECT : INIT_CHAR_INVERSE;
      drive(11'h400);
      drive('0);
      settle();
      rd(OFS_IRQ_STATUS, rdat);
      chk("valid convention", rdat, 32'h0);
    end
    // enabled pulse events raise the interrupt at once
    wr(OFS_IRQ_ENABLE, 32'h0000_0568);
    conv_char <= 8'h55;
    drive(11'h540);
    settle();
    chk("irq on pulses", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STATUS, rdat);
    chk("pulse flags", rdat, 32'h0000_0540);
    wr(OFS_IRQ_ENABLE, 32'h0);
    #1;
    chk("irq disabled", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h0000_0540);
    drive('0);
    // a write-one in the cycle of a new event must not lose it
    @(posedge clock);
    req <= 11'h008;
    reg_addr <= OFS_IRQ_STATUS;
    reg_wdata <= 32'h0000_0008;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    req <= '0;
    settle();
    rd(OFS_IRQ_STATUS, rdat);
    chk("set beats clear", rdat, 32'h0000_0008);
    wr(OFS_IRQ_STATUS, 32'h0000_0008);
    rd(OFS_IRQ_STATUS, rdat);
    chk("w1c after set", rdat, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
